// File: rtl/sdu_core.sv
// Notes on behaviour
// - Global pointer holds 32-bit base and 16-bit limit, fully readable.
// - Selector table bit 0 picks global table, 1 picks local table.
// - Tables hold 8192 eight-byte entries; global entry 0 is null.
// - Global pointer load at 16-bit size keeps only a 24-bit base.
// - Vector pointer holds base and limit for 256 eight-byte gates.
// - Table pointer loads privileged; local selector only in protected mode.
// - Local selector load fetches from global table, cached until reload.
// - Base assembled from +4 bits 31-24, +4 bits 7-0, +0 bits 31-16.
// - Limit from +4 bits 19-16 and +0 bits 15-0; real mode 0FFFFh.
// - Upper word bit 23 selects byte or 4K-page limit granularity.
// - Upper word bit 22 gives default 16 or 32-bit size.
// - Bit 15 present, 14-13 privilege, 12 kind, 20 spare bit.
// - System types: 0010 local table, 1001 idle task, 1011 busy task.
// - Application bit 11 executable; bit 10 expand-down or conforming.
// - Application bit 9 read/write permission; bit 8 accessed.
// - Gate: offset, selector and parameter count from fixed fields.
// - Gate type codes for call, task, interrupt and trap gates.
// - Trap and interrupt gates only from vector table; task gates anywhere.
// - Task pointer: 16-bit selector, protected mode, loads at level 0.
// - Task pointer load fetches task descriptor from global table, cached.
// - 32-bit task block: link 0, pdir 1C, ip 20, lsel 60, iomap 64.
// - 16-bit task block: link 0, ip E, flags 10, lsel 2A.
// - Current privilege level reported; level 0 most privileged.
`timescale 1ns/10ps
`default_nettype none
module sdu_core
   import sdu_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Processor state
   input wire logic prot_mode,
   input wire logic cpl_wr,
   input wire logic [1:0] cpl_new,
   output logic [1:0] current_privilege,
   // Operation request
   input wire logic op_valid,
   output logic op_ready,
   input wire sdu_op_type op_code,
   input wire logic op_size32,
   input wire logic [15:0] op_sel,
   input wire logic [7:0] op_vector,
   input wire sdu_ptr_type op_ptr,
   input wire sdu_tsave_type op_tsave,
   input wire logic op_tsb32,
   // Operation result
   output logic op_done,
   output sdu_fault_type op_fault,
   output logic desc_valid,
   output logic desc_null,
   output sdu_desc_type desc_out,
   // Register read-back
   input wire sdu_rd_type rd_sel,
   output logic [47:0] rd_data,
   // Descriptor memory
   output logic mem_rd_req,
   output logic mem_wr_req,
   output logic mem_wr_wide,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   input wire logic [63:0] mem_rdata,
   input wire logic mem_ack
);

   typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_SAVE, ST_DONE} sdu_state_type;

   function automatic sdu_desc_type sdu_decode(input logic [63:0] raw);
      logic [31:0] hi;
      logic [31:0] lo;
      sdu_desc_type d;
      hi = raw[63:32];
      lo = raw[31:0];
      d.base = {hi[31:24], hi[7:0], lo[31:16]};
      d.limit = {hi[19:16], lo[15:0]};
      d.gran = hi[SDU_GRAN_BIT];
      d.eff_limit = d.gran ? {d.limit, SDU_PAGE_FILL} : {12'h000, d.limit};
      d.def32 = hi[SDU_DSIZE_BIT];
      d.spare = hi[SDU_SPARE_BIT];
      d.present = hi[SDU_PRES_BIT];
      d.descriptor_privilege = hi[SDU_DPL_HI:SDU_DPL_LO];
      d.app_kind = hi[SDU_KIND_BIT];
      d.dtype = hi[SDU_TYPE_HI:SDU_TYPE_LO];
      d.exec = hi[SDU_EXEC_BIT];
      d.dir_conf = hi[SDU_DIRCONF_BIT];
      d.rw = hi[SDU_RW_BIT];
      d.accessed = hi[SDU_ACC_BIT];
      d.gate_off = {hi[31:16], lo[15:0]};
      d.gate_sel = lo[31:16];
      d.gate_params = hi[SDU_PARAM_HI:0];
      return d;
   endfunction : sdu_decode

   function automatic sdu_wr_type sdu_save_entry(input logic wide, input logic [2:0] idx,
                                                 input sdu_tsave_type s,
                                                 input logic [15:0] lsel);
      sdu_wr_type w;
      w.wide = wide;
      w.ofs = SDU_T32_LINK;
      w.data = {16'h0000, s.back_link};
      if (wide) begin
         case (idx)
            3'h1: begin w.ofs = SDU_T32_PDIR; w.data = s.page_dir; end
            3'h2: begin w.ofs = SDU_T32_IP; w.data = s.ip; end
            3'h3: begin w.ofs = SDU_T32_LSEL; w.data = {16'h0000, lsel}; end
            3'h4: begin w.ofs = SDU_T32_IOMAP; w.data = {s.io_map, 16'h0000}; end
            default: w.ofs = SDU_T32_LINK;
         endcase
      end else begin
         case (idx)
            3'h1: begin w.ofs = SDU_T16_IP; w.data = {16'h0000, s.ip[15:0]}; end
            3'h2: begin w.ofs = SDU_T16_FLAGS; w.data = {16'h0000, s.flags[15:0]}; end
            3'h3: begin w.ofs = SDU_T16_LSEL; w.data = {16'h0000, lsel}; end
            default: w.ofs = SDU_T16_LINK;
         endcase
      end
      return w;
   endfunction : sdu_save_entry

   sdu_state_type st_q;
   sdu_ptr_type gtp_q;
   sdu_ptr_type vtp_q;
   logic [15:0] local_sel_q;
   logic [15:0] task_sel_q;
   sdu_desc_type local_desc_q;
   sdu_desc_type task_desc_q;
   logic local_valid_q;
   logic task_valid_q;
   logic [1:0] cpl_q;
   sdu_op_type cur_op_q;
   logic [15:0] cur_sel_q;
   logic cur_from_vec_q;
   sdu_tsave_type tsave_q;
   logic save_wide_q;
   logic [2:0] save_idx_q;
   logic mem_rd_q;
   logic mem_wr_q;
   logic mem_wide_q;
   logic [31:0] mem_addr_q;
   logic [31:0] mem_wdata_q;
   logic done_q;
   sdu_fault_type fault_q;
   logic desc_valid_q;
   logic desc_null_q;
   sdu_desc_type desc_q;
   logic [47:0] rd_data_q;

   // Request decode
   wire accept = op_valid && (st_q == ST_IDLE);
   wire op_is_lg = (op_code == SDU_OP_LOAD_GLOBAL);
   wire op_is_lv = (op_code == SDU_OP_LOAD_VECTOR);
   wire op_is_ll = (op_code == SDU_OP_LOAD_LOCAL);
   wire op_is_lt = (op_code == SDU_OP_LOAD_TASK);
   wire op_is_seg = (op_code == SDU_OP_SEG_LOAD);
   wire op_is_gsel = (op_code == SDU_OP_GATE_SEL);
   wire op_is_gvec = (op_code == SDU_OP_GATE_VEC);
   wire op_is_save = (op_code == SDU_OP_TASK_SAVE);
   wire sel_local = op_sel[SDU_TI_BIT];
   wire [12:0] sel_index = op_sel[15:3];
   wire sel_null = !sel_local && (sel_index == 13'h0000);
   wire [31:0] sel_ofs = {16'h0000, sel_index, 3'b000};
   wire [31:0] sel_end = {16'h0000, sel_index, 3'b111};
   wire [31:0] vec_ofs = {21'h000000, op_vector, 3'b000};
   wire [31:0] vec_end = {21'h000000, op_vector, 3'b111};
   wire [31:0] tbl_base = sel_local ? local_desc_q.base : gtp_q.base;
   wire [31:0] tbl_limit = sel_local ? local_desc_q.eff_limit : {16'h0000, gtp_q.limit};
   wire needs_sel = op_is_ll || op_is_lt || op_is_seg || op_is_gsel;
   wire is_fetch_op = op_is_ll || op_is_lt || op_is_gsel || op_is_gvec || (op_is_seg && prot_mode);
   wire real_seg = op_is_seg && !prot_mode;
   wire seg_null = op_is_seg && prot_mode && sel_null;

   // Checks made when a request is taken
   wire priv_fail = prot_mode && (cpl_q != 2'h0) && (op_is_lg || op_is_lv || op_is_lt);
   wire mode_fail = !prot_mode && (op_is_ll || op_is_lt || op_is_gsel || op_is_save);
   wire table_fail = (op_is_ll || op_is_lt) && sel_local;
   wire null_fail = (op_is_ll || op_is_lt || op_is_gsel) && sel_null;
   wire nolocal_fail = needs_sel && prot_mode && sel_local && !local_valid_q;
   wire limit_fail = (needs_sel && prot_mode && !sel_null && (sel_end > tbl_limit))
                     || (op_is_gvec && (vec_end > {16'h0000, vtp_q.limit}));
   wire notask_fail = op_is_save && !task_valid_q;
   sdu_fault_type pre_fault;
   always_comb begin
      pre_fault = SDU_FLT_NONE;
      if (mode_fail) pre_fault = SDU_FLT_MODE;
      else if (priv_fail) pre_fault = SDU_FLT_PRIV;
      else if (table_fail) pre_fault = SDU_FLT_TABLE;
      else if (null_fail) pre_fault = SDU_FLT_NULLSEL;
      else if (nolocal_fail || notask_fail) pre_fault = SDU_FLT_NOLOCAL;
      else if (limit_fail) pre_fault = SDU_FLT_LIMIT;
   end
   wire pre_ok = (pre_fault == SDU_FLT_NONE);
   wire [31:0] fetch_addr = op_is_gvec ? (vtp_q.base + vec_ofs) : (tbl_base + sel_ofs);

   // Checks on the fetched descriptor
   wire sdu_desc_type fetched = sdu_decode(mem_rdata);
   wire ft_trapint = (fetched.dtype == SDU_GT_INT16) || (fetched.dtype == SDU_GT_TRAP16)
                     || (fetched.dtype == SDU_GT_INT32) || (fetched.dtype == SDU_GT_TRAP32);
   wire ft_callgate = (fetched.dtype == SDU_GT_CALL16) || (fetched.dtype == SDU_GT_CALL32);
   wire ft_taskgate = (fetched.dtype == SDU_GT_TASK);
   wire ll_type_bad = fetched.app_kind || (fetched.dtype != SDU_SYS_LOCAL);
   wire lt_type_bad = fetched.app_kind || (fetched.dtype != SDU_SYS_TASK_IDLE);
   wire gvec_type_bad = fetched.app_kind || !(ft_trapint || ft_taskgate);
   wire gsel_type_bad = fetched.app_kind || !(ft_callgate || ft_taskgate);
   sdu_fault_type post_fault;
   always_comb begin
      post_fault = SDU_FLT_NONE;
      if (!fetched.present) post_fault = SDU_FLT_ABSENT;
      else begin
         case (cur_op_q)
            SDU_OP_LOAD_LOCAL: if (ll_type_bad) post_fault = SDU_FLT_TYPE;
            SDU_OP_LOAD_TASK: if (lt_type_bad) post_fault = SDU_FLT_TYPE;
            SDU_OP_GATE_VEC: if (gvec_type_bad) post_fault = SDU_FLT_TYPE;
            SDU_OP_GATE_SEL: if (gsel_type_bad) post_fault = SDU_FLT_TYPE;
            default: post_fault = SDU_FLT_NONE;
         endcase
      end
   end
   wire fetch_end = (st_q == ST_FETCH) && mem_ack;
   wire fetch_ok = fetch_end && (post_fault == SDU_FLT_NONE);

   // Task-state save sequencing
   wire [2:0] save_last = save_wide_q ? SDU_T32_LAST : SDU_T16_LAST;
   wire save_step = (st_q == ST_SAVE) && mem_ack;
   wire save_end = save_step && (save_idx_q == save_last);
   wire [2:0] save_idx_nx = save_idx_q + 3'h1;
   wire sdu_wr_type save_first = sdu_save_entry(op_tsb32, 3'h0, op_tsave, local_sel_q);
   wire sdu_wr_type save_next = sdu_save_entry(save_wide_q, save_idx_nx, tsave_q, local_sel_q);

   // Real-mode segment image
   sdu_desc_type real_desc;
   always_comb begin
      real_desc = '0;
      real_desc.base = {12'h000, op_sel, 4'h0};
      real_desc.limit = SDU_REAL_LIMIT[19:0];
      real_desc.eff_limit = SDU_REAL_LIMIT;
      real_desc.present = 1'b1;
      real_desc.app_kind = 1'b1;
   end

   // Base kept whole at 32-bit size, top byte dropped at 16-bit size
   wire [31:0] gtp_base_in = op_size32 ? op_ptr.base : {8'h00, op_ptr.base[23:0]};

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_q <= ST_IDLE;
         cur_op_q <= SDU_OP_LOAD_GLOBAL;
         cur_sel_q <= SDU_RST_SEL;
         cur_from_vec_q <= 1'b0;
         tsave_q <= '0;
         save_wide_q <= 1'b0;
         save_idx_q <= 3'h0;
         mem_rd_q <= 1'b0;
         mem_wr_q <= 1'b0;
         mem_wide_q <= 1'b0;
         mem_addr_q <= SDU_RST_BASE;
         mem_wdata_q <= 32'h00000000;
         done_q <= 1'b0;
         fault_q <= SDU_FLT_NONE;
      end else begin
         done_q <= 1'b0;
         case (st_q)
            ST_IDLE: begin
               if (accept) begin
                  cur_op_q <= op_code;
                  cur_sel_q <= op_sel;
                  cur_from_vec_q <= op_is_gvec;
                  fault_q <= pre_fault;
                  if (pre_ok && op_is_save) begin
                     tsave_q <= op_tsave;
                     save_wide_q <= op_tsb32;
                     save_idx_q <= 3'h0;
                     mem_wr_q <= 1'b1;
                     mem_wide_q <= save_first.wide;
                     mem_addr_q <= task_desc_q.base + {24'h000000, save_first.ofs};
                     mem_wdata_q <= save_first.data;
                     st_q <= ST_SAVE;
                  end else if (pre_ok && is_fetch_op && !seg_null) begin
                     mem_rd_q <= 1'b1;
                     mem_addr_q <= fetch_addr;
                     st_q <= ST_FETCH;
                  end else begin
                     st_q <= ST_DONE;
                  end
               end
            end
            ST_FETCH: begin
               if (mem_ack) begin
                  mem_rd_q <= 1'b0;
                  fault_q <= post_fault;
                  st_q <= ST_DONE;
               end
            end
            ST_SAVE: begin
               if (save_end) begin
                  mem_wr_q <= 1'b0;
                  st_q <= ST_DONE;
               end else if (save_step) begin
                  save_idx_q <= save_idx_nx;
                  mem_wide_q <= save_next.wide;
                  mem_addr_q <= task_desc_q.base + {24'h000000, save_next.ofs};
                  mem_wdata_q <= save_next.data;
               end
            end
            ST_DONE: begin
               done_q <= 1'b1;
               st_q <= ST_IDLE;
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // System registers and hidden caches
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         gtp_q <= '{SDU_RST_BASE, SDU_RST_LIMIT};
         vtp_q <= '{SDU_RST_BASE, SDU_RST_LIMIT};
         local_sel_q <= SDU_RST_SEL;
         task_sel_q <= SDU_RST_SEL;
         local_desc_q <= '0;
         task_desc_q <= '0;
         local_valid_q <= 1'b0;
         task_valid_q <= 1'b0;
      end else begin
         if (accept && pre_ok && op_is_lg) gtp_q <= '{gtp_base_in, op_ptr.limit};
         if (accept && pre_ok && op_is_lv) vtp_q <= op_ptr;
         if (fetch_ok && (cur_op_q == SDU_OP_LOAD_LOCAL)) begin
            local_sel_q <= cur_sel_q;
            local_desc_q <= fetched;
            local_valid_q <= 1'b1;
         end
         if (fetch_ok && (cur_op_q == SDU_OP_LOAD_TASK)) begin
            task_sel_q <= cur_sel_q;
            task_desc_q <= fetched;
            task_valid_q <= 1'b1;
         end
      end
   end

   // Result descriptor and privilege level
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         desc_q <= '0;
         desc_valid_q <= 1'b0;
         desc_null_q <= 1'b0;
         cpl_q <= SDU_RST_CPL;
      end else begin
         if (cpl_wr) cpl_q <= cpl_new;
         if (accept) begin
            desc_valid_q <= pre_ok && real_seg;
            desc_null_q <= pre_ok && seg_null;
            if (pre_ok && real_seg) desc_q <= real_desc;
         end else if (fetch_end) begin
            desc_valid_q <= (post_fault == SDU_FLT_NONE);
            desc_q <= fetched;
         end
      end
   end

   // Read-back of the system registers
   logic [47:0] rd_mux;
   always_comb begin
      case (rd_sel)
         SDU_RD_GLOBAL: rd_mux = {gtp_q.base, gtp_q.limit};
         SDU_RD_VECTOR: rd_mux = {vtp_q.base, vtp_q.limit};
         SDU_RD_LOCAL: rd_mux = {32'h00000000, local_sel_q};
         SDU_RD_TASK: rd_mux = {32'h00000000, task_sel_q};
         default: rd_mux = 48'h000000000000;
      endcase
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) rd_data_q <= 48'h000000000000;
      else rd_data_q <= rd_mux;
   end

   assign op_ready = (st_q == ST_IDLE);
   assign current_privilege = cpl_q;
   assign op_done = done_q;
   assign op_fault = fault_q;
   assign desc_valid = desc_valid_q;
   assign desc_null = desc_null_q;
   assign desc_out = desc_q;
   assign rd_data = rd_data_q;
   assign mem_rd_req = mem_rd_q;
   assign mem_wr_req = mem_wr_q;
   assign mem_wr_wide = mem_wide_q;
   assign mem_addr = mem_addr_q;
   assign mem_wdata = mem_wdata_q;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   chk_gtp_narrow_base: assert property (
      accept && op_is_lg && pre_ok && !op_size32 |=> gtp_q.base[31:24] == 8'h00
         && gtp_q.base[23:0] == $past(op_ptr.base[23:0]))
      else $error("global base kept upper byte at 16-bit size");
   chk_table_pick: assert property (
      accept && op_is_seg && prot_mode && sel_local && pre_ok
         |=> mem_rd_q && mem_addr_q == local_desc_q.base + {16'h0000, $past(op_sel[15:3]), 3'b000})
      else $error("local selector fetched from wrong table address");
   chk_null_nofetch: assert property (
      accept && op_is_seg && prot_mode && sel_null |=> !mem_rd_q ##1 op_done && desc_null)
      else $error("null global selector caused a fetch");
   chk_real_limit: assert property (
      accept && real_seg |=> desc_valid && desc_out.eff_limit == 32'h0000FFFF)
      else $error("real mode limit not 0FFFFh");
   chk_local_cache: assert property (
      fetch_ok && cur_op_q == SDU_OP_LOAD_LOCAL |=> local_valid_q
         && local_desc_q.dtype == SDU_SYS_LOCAL && !local_desc_q.app_kind)
      else $error("local table descriptor not cached");
   chk_gate_source: assert property (
      fetch_end && !cur_from_vec_q && ft_trapint |-> ##2 op_done && op_fault == SDU_FLT_TYPE)
      else $error("trap or interrupt gate accepted outside vector table");
   chk_task_priv: assert property (
      accept && op_is_lt && prot_mode && cpl_q != 2'h0 |=> !mem_rd_q ##1 op_done
         && op_fault == SDU_FLT_PRIV)
      else $error("task pointer load allowed away from level 0");
   chk_page_limit: assert property (
      desc_valid && desc_out.gran |-> desc_out.eff_limit == {desc_out.limit, 12'hFFF})
      else $error("page granular limit wrongly formed");
   chk_tsb_lsel: assert property (
      mem_wr_req && save_wide_q && save_idx_q == 3'h3
         |-> mem_addr_q == task_desc_q.base + 32'h00000060 && mem_wdata_q[15:0] == local_sel_q)
      else $error("local selector not saved at offset 60h");
   chk_tsb16_end: assert property (
      save_step && !save_wide_q && save_idx_q == 3'h3 |-> mem_addr_q == task_desc_q.base + 32'h2A)
      else $error("16-bit task block did not end at offset 2Ah");

   cov_local_load: cover property (fetch_ok && cur_op_q == SDU_OP_LOAD_LOCAL);
   cov_vector_gate: cover property (fetch_ok && cur_op_q == SDU_OP_GATE_VEC);
   cov_save16: cover property (save_end && !save_wide_q);
   cov_save32: cover property (save_end && save_wide_q);

endmodule : sdu_core
`default_nettype wire

// File: shared/sdu_pkg.sv
package sdu_pkg;

   // Table geometry
   localparam int SDU_TABLE_ENTRIES = 8192;
   localparam int SDU_VECTOR_ENTRIES = 256;
   localparam int SDU_ENTRY_SHIFT = 3;

   // Upper descriptor word (+4) field positions, and the selector table bit
   localparam int SDU_GRAN_BIT = 23;
   localparam int SDU_DSIZE_BIT = 22;
   localparam int SDU_SPARE_BIT = 20;
   localparam int SDU_PRES_BIT = 15;
   localparam int SDU_DPL_HI = 14;
   localparam int SDU_DPL_LO = 13;
   localparam int SDU_KIND_BIT = 12;
   localparam int SDU_TYPE_HI = 11;
   localparam int SDU_TYPE_LO = 8;
   localparam int SDU_EXEC_BIT = 11;
   localparam int SDU_DIRCONF_BIT = 10;
   localparam int SDU_RW_BIT = 9;
   localparam int SDU_ACC_BIT = 8;
   localparam int SDU_PARAM_HI = 4;
   localparam int SDU_TI_BIT = 2;

   // System and gate type codes
   localparam logic [3:0] SDU_SYS_LOCAL = 4'h2;
   localparam logic [3:0] SDU_SYS_TASK_IDLE = 4'h9;
   localparam logic [3:0] SDU_SYS_TASK_BUSY = 4'hB;
   localparam logic [3:0] SDU_GT_CALL16 = 4'h4;
   localparam logic [3:0] SDU_GT_TASK = 4'h5;
   localparam logic [3:0] SDU_GT_INT16 = 4'h6;
   localparam logic [3:0] SDU_GT_TRAP16 = 4'h7;
   localparam logic [3:0] SDU_GT_CALL32 = 4'hC;
   localparam logic [3:0] SDU_GT_INT32 = 4'hE;
   localparam logic [3:0] SDU_GT_TRAP32 = 4'hF;

   localparam logic [31:0] SDU_REAL_LIMIT = 32'h0000FFFF;
   localparam logic [11:0] SDU_PAGE_FILL = 12'hFFF;

   // Task-state block offsets, 32-bit layout
   localparam logic [7:0] SDU_T32_LINK = 8'h00;
   localparam logic [7:0] SDU_T32_PDIR = 8'h1C;
   localparam logic [7:0] SDU_T32_IP = 8'h20;
   localparam logic [7:0] SDU_T32_LSEL = 8'h60;
   localparam logic [7:0] SDU_T32_IOMAP = 8'h64;
   // Task-state block offsets, 16-bit layout; last save step index of each layout
   localparam logic [7:0] SDU_T16_LINK = 8'h00;
   localparam logic [7:0] SDU_T16_IP = 8'h0E;
   localparam logic [7:0] SDU_T16_FLAGS = 8'h10;
   localparam logic [7:0] SDU_T16_LSEL = 8'h2A;
   localparam logic [2:0] SDU_T32_LAST = 3'h4;
   localparam logic [2:0] SDU_T16_LAST = 3'h3;

   // Reset values
   localparam logic [31:0] SDU_RST_BASE = 32'h00000000;
   localparam logic [15:0] SDU_RST_LIMIT = 16'h0000;
   localparam logic [15:0] SDU_RST_SEL = 16'h0000;
   localparam logic [1:0] SDU_RST_CPL = 2'h0;

   typedef enum logic [2:0] {
      SDU_OP_LOAD_GLOBAL, SDU_OP_LOAD_VECTOR, SDU_OP_LOAD_LOCAL, SDU_OP_LOAD_TASK,
      SDU_OP_SEG_LOAD, SDU_OP_GATE_SEL, SDU_OP_GATE_VEC, SDU_OP_TASK_SAVE
   } sdu_op_type;

   typedef enum logic [3:0] {
      SDU_FLT_NONE, SDU_FLT_PRIV, SDU_FLT_MODE, SDU_FLT_TABLE, SDU_FLT_NULLSEL,
      SDU_FLT_LIMIT, SDU_FLT_NOLOCAL, SDU_FLT_TYPE, SDU_FLT_ABSENT
   } sdu_fault_type;

   typedef enum logic [1:0] {
      SDU_RD_GLOBAL, SDU_RD_VECTOR, SDU_RD_LOCAL, SDU_RD_TASK
   } sdu_rd_type;

   typedef struct packed {
      logic [31:0] base;
      logic [15:0] limit;
   } sdu_ptr_type;

   typedef struct packed {
      logic [31:0] base;
      logic [19:0] limit;
      logic [31:0] eff_limit;
      logic gran;
      logic def32;
      logic spare;
      logic present;
      logic [1:0] descriptor_privilege;
      logic app_kind;
      logic [3:0] dtype;
      logic exec;
      logic dir_conf;
      logic rw;
      logic accessed;
      logic [31:0] gate_off;
      logic [15:0] gate_sel;
      logic [4:0] gate_params;
   } sdu_desc_type;

   typedef struct packed {
      logic [15:0] back_link;
      logic [31:0] page_dir;
      logic [31:0] ip;
      logic [31:0] flags;
      logic [15:0] io_map;
   } sdu_tsave_type;

   typedef struct packed {
      logic [7:0] ofs;
      logic [31:0] data;
      logic wide;
   } sdu_wr_type;

endpackage : sdu_pkg

// File: tb/sdu_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module sdu_mem_model
   import sdu_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Memory side
   input wire logic rd_req,
   input wire logic wr_req,
   input wire logic [31:0] addr,
   output logic [63:0] rdata,
   output logic ack
);
   logic [63:0] desc;
   logic [1:0] cnt_q;
   logic [1:0] lat_q;
   // Latency rotates 0..3 so the core sees prompt and slow answers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ack <= 1'b0;
         cnt_q <= 2'h0;
         lat_q <= 2'h0;
      end else if (ack || !(rd_req || wr_req)) begin
         ack <= 1'b0;
         cnt_q <= 2'h0;
      end else if (cnt_q == lat_q) begin
         ack <= 1'b1;
         lat_q <= lat_q + 2'h1;
      end else begin
         cnt_q <= cnt_q + 2'h1;
      end
   end
   // Entries repeat every 32 bytes: trap gate, data segment, local table, idle task
   always_comb begin
      case (addr[4:3])
         2'h1: desc = 64'hABC392CD_12345678;
         2'h2: desc = 64'h00008200_4000FFFF;
         2'h3: desc = 64'h00008900_50000067;
         default: desc = 64'h00008F00_00081000;
      endcase
   end
   // Outside the answer cycle the data lines show garbage
   assign rdata = ack ? desc : ~desc;
endmodule : sdu_mem_model
`default_nettype wire

// File: tb/sdu_core_test.sv
`timescale 1ns/10ps
`default_nettype none
`define CMP(a, b, m) begin checks++; if ((a) !== (b)) begin error_cnt++; $display("MISMATCH %0t %s", $time, m); end end
module sdu_core_test
   import sdu_pkg::*;
;
   logic mclk = 0, rst = 1, prot_mode = 1, cpl_wr = 0, op_valid = 0, op_size32 = 0;
   logic op_ready, op_done, desc_valid, desc_null, mem_rd_req, mem_wr_req, mem_wr_wide, mem_ack;
   logic [1:0] cpl_new = 2'h0, current_privilege;
   logic [15:0] op_sel = 16'h0000;
   logic [31:0] mem_addr, mem_wdata, gbase, wr_q[$];
   logic op_tsb32 = 1'b1;
   logic [47:0] rd_data;
   logic [63:0] mem_rdata;
   logic [69:0] e;
   logic [69:0] exp_q[$];
   sdu_op_type op_code = SDU_OP_LOAD_GLOBAL;
   sdu_ptr_type op_ptr = '0;
   sdu_rd_type rd_sel = SDU_RD_LOCAL;
   sdu_fault_type op_fault;
   sdu_desc_type desc_out;
   int seed, checks = 0, error_cnt = 0;
   always #12.5 mclk = ~mclk;
   sdu_core dut (.mclk(mclk), .rst(rst), .prot_mode(prot_mode), .cpl_wr(cpl_wr),
      .cpl_new(cpl_new), .current_privilege(current_privilege), .op_valid(op_valid),
      .op_ready(op_ready), .op_code(op_code), .op_size32(op_size32), .op_sel(op_sel),
      .op_vector(8'h00), .op_ptr(op_ptr), .op_tsave('0), .op_tsb32(op_tsb32),
      .op_done(op_done), .op_fault(op_fault), .desc_valid(desc_valid), .desc_null(desc_null),
      .desc_out(desc_out), .rd_sel(rd_sel), .rd_data(rd_data), .mem_rd_req(mem_rd_req),
      .mem_wr_req(mem_wr_req), .mem_wr_wide(mem_wr_wide), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
   sdu_mem_model mem (.mclk(mclk), .rst(rst), .rd_req(mem_rd_req), .wr_req(mem_wr_req),
      .addr(mem_addr), .rdata(mem_rdata), .ack(mem_ack));
   task automatic stop_test;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : stop_test
   // Issue one request at a falling edge, then wait for the core to go idle again
   task automatic op(input sdu_op_type c, input logic [15:0] s, input logic [69:0] x);
      op_code = c;
      op_sel = s;
      op_valid = 1'b1;
      exp_q.push_back(x);
      @(negedge mclk);
      op_valid = 1'b0;
      while (!op_ready) @(negedge mclk);
   endtask : op
   always @(posedge mclk) begin
      if (mem_wr_req && mem_ack) begin
         `CMP(mem_addr, wr_q.pop_front(), "save address")
         `CMP(mem_wr_wide, op_tsb32, "save width")
      end
      if (op_done) begin
         e = exp_q.pop_front();
         `CMP(op_fault, sdu_fault_type'(e[67:64]), "fault code")
         if (e[69]) `CMP(desc_out.base, e[63:32], "segment base")
         if (e[68]) `CMP(desc_out.eff_limit, e[31:0], "effective limit")
      end
   end
   initial begin
      #(25ns * 4000);
      error_cnt++;
      stop_test;
   end
   initial begin
      seed = 97;
      gbase = $random(seed) & 32'hFFFFFFE0;
      op_ptr = {gbase, 16'hFFFF};
      repeat (16) @(negedge mclk);
      rst = 1'b0;
      op(SDU_OP_LOAD_GLOBAL, 16'h0000, {2'b00, SDU_FLT_NONE, 64'h0});
      rd_sel = SDU_RD_GLOBAL;
      repeat (2) @(negedge mclk);
      `CMP(rd_data, {8'h00, gbase[23:0], 16'hFFFF}, "global readback")
      op(SDU_OP_SEG_LOAD, 16'h0008, {2'b11, SDU_FLT_NONE, 64'hABCD1234_35678FFF});
      op(SDU_OP_LOAD_LOCAL, 16'h000C, {2'b00, SDU_FLT_TABLE, 64'h0});
      op(SDU_OP_SEG_LOAD, 16'h0004, {2'b00, SDU_FLT_NOLOCAL, 64'h0});
      op(SDU_OP_LOAD_TASK, 16'h0008, {2'b00, SDU_FLT_TYPE, 64'h0});
      op(SDU_OP_SEG_LOAD, 16'h0000, {2'b00, SDU_FLT_NONE, 64'h0});
      `CMP(desc_null, 1'b1, "null selector flag")
      op(SDU_OP_LOAD_LOCAL, 16'h0010, {2'b11, SDU_FLT_NONE, 64'h00004000_0000FFFF});
      op(SDU_OP_SEG_LOAD, 16'h000C, {2'b11, SDU_FLT_NONE, 64'hABCD1234_35678FFF});
      op(SDU_OP_GATE_SEL, 16'h0004, {2'b00, SDU_FLT_TYPE, 64'h0});
      op(SDU_OP_LOAD_VECTOR, 16'h0000, {2'b00, SDU_FLT_NONE, 64'h0});
      op(SDU_OP_GATE_VEC, 16'h0000, {2'b00, SDU_FLT_NONE, 64'h0});
      op(SDU_OP_LOAD_TASK, 16'h0018, {2'b11, SDU_FLT_NONE, 64'h00005000_00000067});
      wr_q = {32'h5000, 32'h501C, 32'h5020, 32'h5060, 32'h5064};
      op(SDU_OP_TASK_SAVE, 16'h0000, {2'b00, SDU_FLT_NONE, 64'h0});
      op_tsb32 = 1'b0;
      wr_q = {32'h5000, 32'h500E, 32'h5010, 32'h502A};
      op(SDU_OP_TASK_SAVE, 16'h0000, {2'b00, SDU_FLT_NONE, 64'h0});
      cpl_new = 2'h1;
      cpl_wr = 1'b1;
      @(negedge mclk);
      cpl_wr = 1'b0;
      @(negedge mclk);
      `CMP(current_privilege, 2'h1, "privilege level")
      op_size32 = 1'b1;
      op(SDU_OP_LOAD_GLOBAL, 16'h0000, {2'b00, SDU_FLT_PRIV, 64'h0});
      op(SDU_OP_LOAD_TASK, 16'h0008, {2'b00, SDU_FLT_PRIV, 64'h0});
      prot_mode = 1'b0;
      op(SDU_OP_LOAD_LOCAL, 16'h0008, {2'b00, SDU_FLT_MODE, 64'h0});
      op(SDU_OP_SEG_LOAD, 16'h1230, {2'b11, SDU_FLT_NONE, 64'h00012300_0000FFFF});
      repeat (4) @(negedge mclk);
      `CMP(exp_q.size() + wr_q.size(), 0, "results missing")
      stop_test;
   end
endmodule : sdu_core_test
`default_nettype wire
